//--- dac_ctrl.sv
// Serial control, power and alert logic of a quad DAC
`timescale 1ns/1ps
module dac_ctrl
  import dac_ctrl_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             link_clk_i,
  input  wire logic             frame_sync_n_i,
  input  wire logic             serial_data_i,
  output logic                  serial_readback_output_o,
  output logic                  serial_readback_oe_n_o,
  input  wire logic [NCHAN-1:0] overcurrent_det_i,
  input  wire logic             overtemp_det_i,
  output logic [NCHAN-1:0]      chan_power_on_o,
  output logic                  reference_power_on_o,
  output logic                  output_update_strobe_o,
  output logic                  clear_strobe_o,
  output logic                  clear_code_choice_o,
  output logic                  overtemp_shutdown_on_o
);
  logic link_rst;
  logic [4:0] cnt_q, cnt_d;
  logic [FRAME_W-2:0] sh_q, sh_d;
  logic [FRAME_W-1:0] frm_q, frm_d;
  logic tog_q, tog_d;
  logic rbo_q, rbo_d;
  logic [FRAME_W-1:0] rb_q, rb_d;

  // Link side: bit counter and shifter, cleared between frames
  assign link_rst = frame_sync_n_i | sys_rst_i;
  always_comb
  begin
    sh_d  = {sh_q[FRAME_W-3:0], serial_data_i};
    cnt_d = (cnt_q < 5'(FRAME_W)) ? cnt_q + 5'd1 : cnt_q;
    frm_d = frm_q;
    tog_d = tog_q;
    rbo_d = 1'b0;
    if (cnt_q < 5'(FRAME_W))
    begin
      rbo_d = rb_q[5'(FRAME_W - 1) - cnt_q];
    end
    if (cnt_q == 5'(FRAME_W - 1))
    begin
      frm_d = {sh_q, serial_data_i};
      tog_d = ~tog_q;
    end
  end

  // Link side shifter registers
  always_ff @(posedge link_clk_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      cnt_q <= 5'h00;
      sh_q  <= '0;
      rbo_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      rbo_q <= rbo_d;
    end
  end

  // Link side frame holder and completion toggle
  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      frm_q <= '0;
      tog_q <= 1'b0;
    end
    else
    begin
      frm_q <= frm_d;
      tog_q <= tog_d;
    end
  end

  assign serial_readback_output_o = rbo_q;

  // Crossing: toggle plus fault inputs through three stages
  logic [NCHAN+1:0] s1_q, s2_q, s3_q;
  logic [NCHAN:0]   flt_q, flt_d;
  logic             seen_q;
  logic             new_frame;
  logic [NCHAN-1:0] oc_f;
  logic             ot_f;
  frame_t           cmd;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      flt_q  <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      s1_q   <= {tog_q, overtemp_det_i, overcurrent_det_i};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      flt_q  <= flt_d;
      seen_q <= new_frame ? s3_q[NCHAN+1] : seen_q;
    end
  end

  // Fault levels count once second and third stage agree
  always_comb
  begin
    for (int i = 0; i <= NCHAN; i++)
    begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  end

  assign new_frame = (s2_q[NCHAN+1] == s3_q[NCHAN+1])
                   && (s3_q[NCHAN+1] != seen_q);
  assign oc_f = flt_q[NCHAN-1:0];
  assign ot_f = flt_q[NCHAN];
  assign cmd  = frame_t'(frm_q);

  // Register state
  logic [3:0]       ctl_q, ctl_d;
  logic [NCHAN-1:0] pu_q, pu_d;
  logic             ref_q, ref_d;
  logic [NCHAN-1:0] oc_q, oc_d;
  logic             ot_q, ot_d;
  logic             upd_q, upd_d;
  logic             clr_q, clr_d;
  logic             wr_pwr, wr_ctl;

  // Power register image as read back
  function automatic logic [DATA_W-1:0] pwr_word(
    input logic [NCHAN-1:0] oc,
    input logic             ot,
    input logic             rf,
    input logic [NCHAN-1:0] pu);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PWR_OC_LSB +: NCHAN] = oc;
    w[PWR_OT]              = ot;
    w[PWR_REF]             = rf;
    w[PWR_PU_LSB +: NCHAN] = pu;
    return w;
  endfunction

  assign wr_pwr = new_frame && !cmd.rd && cmd.sel == SEL_PWR;
  assign wr_ctl = new_frame && !cmd.rd && cmd.sel == SEL_CTL;

  // Command decode, power and alert next state
  always_comb
  begin
    ctl_d = ctl_q;
    pu_d  = pu_q;
    ref_d = ref_q;
    oc_d  = oc_q;
    ot_d  = ot_q;
    rb_d  = rb_q;
    upd_d = 1'b0;
    clr_d = 1'b0;
    if (wr_pwr)
    begin
      pu_d  = cmd.data[PWR_PU_LSB +: NCHAN];
      ref_d = cmd.data[PWR_REF];
      if (!ot_f)
      begin
        ot_d = 1'b0;
      end
      oc_d = oc_q & ~(cmd.data[PWR_PU_LSB +: NCHAN] & ~oc_f);
    end
    if (wr_ctl)
    begin
      unique case (cmd.addr)
        FN_FLAGS: ctl_d = cmd.data[3:0];
        FN_CLEAR:
        begin
          clr_d = 1'b1;
          upd_d = 1'b1;
        end
        FN_LOAD:  upd_d = 1'b1;
        default:  ctl_d = ctl_q;
      endcase
    end
    if (new_frame && cmd.rd)
    begin
      rb_d = {cmd.rd, cmd.zero, cmd.sel, cmd.addr, 16'h0000};
      if (cmd.sel == SEL_PWR)
      begin
        rb_d[DATA_W-1:0] = pwr_word(oc_q, ot_q, ref_q, pu_q);
      end
      else if (cmd.sel == SEL_CTL)
      begin
        rb_d[3:0] = ctl_q;
      end
    end
    // Fault handling wins over any host write this cycle
    for (int i = 0; i < NCHAN; i++)
    begin
      if (oc_f[i])
      begin
        oc_d[i] = 1'b1;
        if (!ctl_q[CTL_CLAMP])
        begin
          pu_d[i] = 1'b0;
        end
      end
      else if (ctl_q[CTL_CLAMP])
      begin
        oc_d[i] = 1'b0;
      end
    end
    if (ot_f && ctl_q[CTL_OT_SHUT])
    begin
      pu_d = '0;
      ot_d = 1'b1;
    end
  end

  // Register the control, power and readback state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctl_q <= CTL_RESET;
      pu_q  <= PU_RESET;
      ref_q <= 1'b0;
      oc_q  <= '0;
      ot_q  <= 1'b0;
      rb_q  <= '0;
      upd_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      pu_q  <= pu_d;
      ref_q <= ref_d;
      oc_q  <= oc_d;
      ot_q  <= ot_d;
      rb_q  <= rb_d;
      upd_q <= upd_d;
      clr_q <= clr_d;
    end
  end

  // Outputs toward the analog side
  assign serial_readback_oe_n_o = ctl_q[CTL_RB_OFF];
  assign chan_power_on_o        = pu_q;
  assign reference_power_on_o   = ref_q;
  assign output_update_strobe_o = upd_q;
  assign clear_strobe_o         = clr_q;
  assign clear_code_choice_o    = ctl_q[CTL_CLEAR_CHOICE];
  assign overtemp_shutdown_on_o = ctl_q[CTL_OT_SHUT];

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic is_idle, is_clr, is_load, is_flag, d0, d4;
  assign is_idle = wr_ctl && cmd.addr == FN_IDLE;
  assign is_clr  = wr_ctl && cmd.addr == FN_CLEAR;
  assign is_load = wr_ctl && cmd.addr == FN_LOAD;
  assign is_flag = wr_ctl && cmd.addr == FN_FLAGS;
  assign d0 = cmd.data[0];
  assign d4 = cmd.data[PWR_REF];

  chk_idle_no_change: assert property (
    is_idle |=> $stable(ctl_q) && !upd_q && !clr_q)
    else $error("idle command changed state");
  chk_clear_updates: assert property (
    is_clr |=> clr_q && upd_q ##1 !clr_q && !upd_q)
    else $error("clear did not pulse both strobes");
  chk_load_updates: assert property (
    is_load |=> upd_q && !clr_q)
    else $error("load did not pulse update");
  chk_readback_off: assert property (
    is_flag |=> serial_readback_oe_n_o == $past(d0))
    else $error("readback enable not from flag");
  chk_oc_power_down: assert property (
    !ctl_q[CTL_CLAMP] |=> (pu_q & $past(oc_f)) == '0)
    else $error("overcurrent channel stayed powered");
  chk_clamp_keeps_on: assert property (
    ctl_q[CTL_CLAMP] && !new_frame && !ot_f |=> $stable(pu_q))
    else $error("clamped channel lost power");
  chk_ot_shutdown: assert property (
    ot_f && ctl_q[CTL_OT_SHUT] |=> pu_q == '0 && ot_q)
    else $error("overtemp did not shut down");
  chk_ot_gated: assert property (
    !ctl_q[CTL_OT_SHUT] && !ot_q |=> !ot_q)
    else $error("thermal alert set while disabled");
  chk_oc_flag_set: assert property (
    |oc_f |=> (oc_q & $past(oc_f)) == $past(oc_f))
    else $error("overcurrent flag not set");
  chk_oc_autoclear: assert property (
    ctl_q[CTL_CLAMP] |=> (oc_q & ~$past(oc_f)) == '0)
    else $error("clamp mode flag did not clear");
  chk_ref_write: assert property (
    wr_pwr |=> reference_power_on_o == $past(d4))
    else $error("reference bit not written");

  cov_clear: cover property (is_clr ##1 clr_q);
  cov_load: cover property (is_load ##1 upd_q);
  cov_oc_down: cover property (
    !ctl_q[CTL_CLAMP] && |(oc_f & pu_q) ##1 1'b1);
  cov_readback: cover property (new_frame && cmd.rd);
endmodule

//--- dac_ctrl_pkg.sv
// Shared constants and types for the DAC control and power logic
package dac_ctrl_pkg;
  // Serial frame layout
  localparam int FRAME_W = 24;
  localparam int DATA_W  = 16;
  localparam int NSYNC   = 3;
  localparam int NCHAN   = 4;
  // Register select codes
  localparam logic [2:0] SEL_PWR = 3'h2;
  localparam logic [2:0] SEL_CTL = 3'h3;
  // Control register field positions
  localparam int CTL_RB_OFF       = 0;
  localparam int CTL_CLEAR_CHOICE = 1;
  localparam int CTL_CLAMP        = 2;
  localparam int CTL_OT_SHUT      = 3;
  localparam logic [3:0] CTL_RESET = 4'h4;
  // Power register field positions
  localparam int PWR_PU_LSB  = 0;
  localparam int PWR_REF     = 4;
  localparam int PWR_OT      = 5;
  localparam int PWR_OC_LSB  = 7;
  localparam logic [3:0] PU_RESET = 4'h0;
  // Control functions picked by the channel address
  typedef enum logic [2:0] {
    FN_IDLE  = 3'b000,
    FN_FLAGS = 3'b001,
    FN_CLEAR = 3'b100,
    FN_LOAD  = 3'b101
  } func_t;
  // One decoded serial frame
  typedef struct packed {
    logic              rd;
    logic              zero;
    logic [2:0]        sel;
    logic [2:0]        addr;
    logic [DATA_W-1:0] data;
  } frame_t;
endpackage

//--- host_model.sv
// Host model sending serial frames and capturing readback
`timescale 1ns/1ps
module host_model
  import dac_ctrl_pkg::*;
(
  output logic      link_clk_o,
  output logic      frame_sync_n_o,
  output logic      serial_data_o,
  input  wire logic readback_i
);
  // Idle levels; link clock stands still between frames
  initial
  begin
    link_clk_o     = 1'b0;
    frame_sync_n_o = 1'b1;
    serial_data_o  = 1'b0;
  end

  // Frame MSB first, cut short if asked; readback on falling edge
  task automatic send(input frame_t f, output logic [FRAME_W-1:0] rb,
                      input int nbits = FRAME_W);
    rb = '0;
    #7 frame_sync_n_o = 1'b0;
    for (int k = FRAME_W - 1; k >= FRAME_W - nbits; k--)
    begin
      serial_data_o = f[k];
      #15 link_clk_o = 1'b1;
      #15 link_clk_o = 1'b0;
      rb[k] = readback_i;
    end
    #15 frame_sync_n_o = 1'b1;
    serial_data_o = ~serial_data_o; // Line flipped from the last bit, no stale level
  endtask
endmodule

//--- quad_dac_control_power_regs_tb.sv
// Self-checking bench for the DAC control and power logic
`timescale 1ns/1ps
module quad_dac_control_power_regs_tb
  import dac_ctrl_pkg::*;
;
  logic             sys_clk_i, sys_rst_i, link_clk, sync_n, sdi;
  logic             rb_out, rb_oe_n, rb_wire, ot, upd, clr, ref_on;
  logic             clr_choice, shut_on;
  logic [23:0]      junk;
  logic [NCHAN-1:0] oc, pu;
  logic [7:0]       st;
  int               errors, num_checks, n_upd, n_clr;

  // Wire level: disabled driver shows the inverse, not a held value
  assign rb_wire = rb_oe_n ? ~rb_out : rb_out;
  assign st      = {rb_oe_n, shut_on, clr_choice, ref_on, pu};

  dac_ctrl dac_ctrl_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk),
    .frame_sync_n_i(sync_n), .serial_data_i(sdi),
    .serial_readback_output_o(rb_out), .serial_readback_oe_n_o(rb_oe_n),
    .overcurrent_det_i(oc), .overtemp_det_i(ot), .chan_power_on_o(pu),
    .reference_power_on_o(ref_on), .output_update_strobe_o(upd),
    .clear_strobe_o(clr), .clear_code_choice_o(clr_choice),
    .overtemp_shutdown_on_o(shut_on));

  host_model host_model_i (
    .link_clk_o(link_clk), .frame_sync_n_o(sync_n),
    .serial_data_o(sdi), .readback_i(rb_wire));

  // System clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Strobe pulse counters
  always @(posedge sys_clk_i)
  begin
    if (upd === 1'b1) n_upd <= n_upd + 1;
    if (clr === 1'b1) n_clr <= n_clr + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge sys_clk_i);
  endtask

  // One frame, then the spacing the link needs
  task automatic frame(input logic r, input logic [2:0] s, input logic [2:0] a,
                       input logic [15:0] d, output logic [23:0] rb);
    host_model_i.send(frame_t'{r, 1'b0, s, a, d}, rb);
    settle();
  endtask

  task automatic wr(input logic [2:0] s, input logic [2:0] a,
                    input logic [15:0] d);
    logic [23:0] rb;
    frame(1'b0, s, a, d, rb);
  endtask

  // Read request, then idle frame that clocks the word out
  task automatic rd_chk(input logic [2:0] s, input logic [15:0] exp);
    logic [23:0] rb;
    frame(1'b1, s, 3'h0, 16'h0000, rb);
    frame(1'b0, SEL_CTL, FN_IDLE, 16'h0000, rb);
    check(rb[15:0], exp);
  endtask

  task automatic summarize;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #500000;
    errors++;
    summarize();
  end

  // Main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    oc = 4'h0;
    ot = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    settle();
    check({8'h00, st}, 16'h0000);
    rd_chk(SEL_CTL, 16'h0004);
    rd_chk(SEL_PWR, 16'h0000);
    // Flag bits written high are ignored; bit 6 kept zero
    wr(SEL_PWR, 3'h0, 16'hFFBF);
    check({8'h00, st}, 16'h001F);
    rd_chk(SEL_PWR, 16'h001F);
    rd_chk(3'h1, 16'h0000);
    repeat (100) @(posedge sys_clk_i);
    wr(SEL_CTL, FN_LOAD, 16'h0000);
    check({n_upd[7:0], n_clr[7:0]}, 16'h0100);
    wr(SEL_CTL, FN_CLEAR, 16'h0000);
    check({n_upd[7:0], n_clr[7:0]}, 16'h0201);
    // Unused address and foreign select change nothing
    wr(SEL_CTL, 3'h2, 16'hFFFF);
    wr(3'h0, 3'h0, 16'h0000);
    check({8'h00, st}, 16'h001F);
    wr(SEL_CTL, FN_FLAGS, 16'h000B);
    check({8'h00, st}, 16'h00FF);
    wr(SEL_CTL, FN_FLAGS, 16'h000A);
    check({8'h00, st}, 16'h007F);
    rd_chk(SEL_CTL, 16'h000A);
    // Clamp off: fault powers channel B down
    oc <= 4'h2;
    settle();
    check({8'h00, st}, 16'h007D);
    rd_chk(SEL_PWR, 16'h011D);
    oc <= 4'h0;
    settle();
    wr(SEL_PWR, 3'h0, 16'h001F);
    rd_chk(SEL_PWR, 16'h001F);
    // Clamp on: channel C stays powered, flag follows fault
    wr(SEL_CTL, FN_FLAGS, 16'h000E);
    oc <= 4'h4;
    settle();
    check({8'h00, st}, 16'h007F);
    rd_chk(SEL_PWR, 16'h021F);
    oc <= 4'h0;
    settle();
    rd_chk(SEL_PWR, 16'h001F);
    // Overtemperature with shutdown enabled, then disabled
    ot <= 1'b1;
    settle();
    check({8'h00, st}, 16'h0070);
    rd_chk(SEL_PWR, 16'h0030);
    ot <= 1'b0;
    settle();
    wr(SEL_PWR, 3'h0, 16'h001F);
    wr(SEL_CTL, FN_FLAGS, 16'h0006);
    ot <= 1'b1;
    settle();
    check({8'h00, st}, 16'h003F);
    rd_chk(SEL_PWR, 16'h001F);
    ot <= 1'b0;
    settle();
    // Cut clear frame is dropped, no strobe follows
    host_model_i.send(frame_t'{1'b0, 1'b0, SEL_CTL, FN_CLEAR, 16'h0000},
                      junk, 12);
    settle();
    check({n_upd[7:0], n_clr[7:0]}, 16'h0201);
    // Many idle frames have passed without strobes
    check({n_upd[7:0], n_clr[7:0]}, 16'h0201);
    // Reset in mid-run restores the defaults
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    settle();
    check({8'h00, st}, 16'h0000);
    rd_chk(SEL_CTL, 16'h0004);
    summarize();
  end
endmodule
